// File: fhpc_ctrl.sv
`timescale 1ns/10ps
module fhpc_ctrl
	import fhpc_pkg::*;
#(
	parameter int NDRV        = 4,
	parameter int STEP_MS_CYC = STEP_UNIT_CYC
) (
	input  wire logic             MCLK,
	input  wire logic             RSTN,
	input  wire logic             CMD_VALID,
	input  wire logic [2:0]       CMD_CODE,
	input  wire logic [1:0]       CMD_DRIVE,
	input  wire logic [7:0]       CMD_ARG,
	input  wire logic             LOW_POWER,
	input  wire logic [NDRV-1:0]  TRACK_ZERO_INPUT,
	input  wire logic             INDEX_PULSE_INPUT,
	input  wire logic             ID_VALID,
	input  wire logic [7:0]       ID_CYL,
	input  wire logic [7:0]       ID_HEAD,
	input  wire logic [7:0]       ID_SECTOR,
	input  wire logic [7:0]       ID_SIZE,
	input  wire logic [2:0]       FMT_FIELD,
	output logic                  BUSY,
	output logic                  INT_OUT,
	output logic [7:0]            FIRST_STATUS_BYTE,
	output logic [7:0]            PRESENT_CYLINDER,
	output logic                  MISSING_ADDRESS_MARK_FLAG,
	output logic [31:0]           ID_CHRN,
	output logic [NDRV-1:0]       STEP_OUT,
	output logic [NDRV-1:0]       DIR_OUT,
	output logic [NDRV-1:0]       DRIVE_ACTIVE,
	output logic [7:0]            FMT_BYTE,
	output logic [7:0]            FMT_COUNT
);
	initial begin
		if (NDRV < 1 || NDRV > 4 || STEP_MS_CYC <= STEP_PULSE_CYC + 1)
			$error("fhpc_ctrl: unsupported parameter values");
	end

	localparam int TW = $clog2(STEP_MS_CYC * 16 + 1);
	localparam logic [TW-1:0] PULSE_T = TW'(STEP_PULSE_CYC);

	typedef enum logic [1:0] {FHPC_D_IDLE, FHPC_D_EVAL, FHPC_D_PULSE, FHPC_D_WAIT} fhpc_drv_e;
	typedef enum logic [1:0] {FHPC_R_IDLE, FHPC_R_SEARCH} fhpc_rid_e;

	// reset released through two flops
	logic       rst_meta_r, rst_n;
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// pin inputs: two flops before any logic reads them
	logic [NDRV-1:0] trk_meta_r, trk_r;
	logic [2:0]      idx_r;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			trk_meta_r <= '0;
			trk_r      <= '0;
			idx_r      <= 3'h0;
		end else begin
			trk_meta_r <= TRACK_ZERO_INPUT;
			trk_r      <= trk_meta_r;
			idx_r      <= {idx_r[1:0], INDEX_PULSE_INPUT};
		end
	end
	wire idx_rise = idx_r[1] & ~idx_r[2];

	// command decode; commands are refused while read-id executes
	logic      rid_busy;
	wire       take    = CMD_VALID & ~rid_busy;
	wire [3:0] drv_sel = 4'h1 << CMD_DRIVE;
	logic      lp_r;
	wire       lp_exit = lp_r & ~LOW_POWER;
	logic [3:0] srt_r;
	logic [NDRV-1:0] clr_int;

	// specify loads the step rate used by every later seek
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			srt_r <= 4'h0;
			lp_r  <= 1'b0;
		end else begin
			lp_r <= LOW_POWER;
			if (take && CMD_CODE == CMD_SPECIFY)
				srt_r <= CMD_ARG[3:0];
		end
	end
	wire [TW-1:0] step_gap = TW'((SRT_BASE - {1'b0, srt_r}) * STEP_MS_CYC);

	logic [7:0] pcn_w  [NDRV];
	logic       pend_w [NDRV];
	logic [1:0] ic_w   [NDRV];
	logic       ec_w   [NDRV];

	// one independent positioner per drive, so seeks overlap
	genvar gi;
	generate
		for (gi = 0; gi < NDRV; gi++) begin : g_drv
			fhpc_drv_e  st_r;
			logic [7:0] pcn_r, ncn_r;
			logic       recal_r, pend_r, ec_r, step_r, dir_r, act_r;
			logic [1:0] ic_r;
			logic [6:0] cnt_r;
			logic [TW-1:0] tmr_r;
			wire start = take && drv_sel[gi] && st_r == FHPC_D_IDLE
				&& (CMD_CODE == CMD_SEEK || CMD_CODE == CMD_RECAL);

			always_ff @(posedge MCLK or negedge rst_n) begin
				if (!rst_n) begin
					st_r    <= FHPC_D_IDLE;
					pcn_r   <= 8'h00;
					ncn_r   <= 8'h00;
					recal_r <= 1'b0;
					pend_r  <= 1'b0;
					ec_r    <= 1'b0;
					ic_r    <= IC_NORMAL;
					step_r  <= 1'b0;
					dir_r   <= 1'b0;
					cnt_r   <= 7'h00;
					tmr_r   <= '0;
					act_r   <= 1'b0;
				end else begin
					// clear first so a same-cycle completion wins
					if (clr_int[gi])
						pend_r <= 1'b0;
					if (lp_exit) begin
						pcn_r  <= 8'h00;
						pend_r <= 1'b0;
						ec_r   <= 1'b0;
						ic_r   <= IC_NORMAL;
					end
					case (st_r)
						FHPC_D_IDLE: begin
							if (start) begin
								recal_r <= CMD_CODE == CMD_RECAL;
								ncn_r   <= CMD_ARG;
								ec_r    <= 1'b0;
								ic_r    <= IC_NORMAL;
								cnt_r   <= 7'h00;
								if (CMD_CODE == CMD_RECAL)
									pcn_r <= 8'h00;
								act_r <= 1'b1;
								st_r <= FHPC_D_EVAL;
							end
						end
						FHPC_D_EVAL: begin
							if (recal_r) begin
								if (trk_r[gi]) begin
									pend_r <= 1'b1;
									act_r  <= 1'b0;
									st_r   <= FHPC_D_IDLE;
								end else if (cnt_r == RECAL_MAX_STEPS) begin
									pend_r <= 1'b1;
									ec_r   <= 1'b1;
									ic_r   <= IC_ABNORMAL;
									act_r  <= 1'b0;
									st_r   <= FHPC_D_IDLE;
								end else begin
									dir_r  <= 1'b0;
									step_r <= 1'b1;
									tmr_r  <= PULSE_T;
									st_r   <= FHPC_D_PULSE;
								end
							end else if (pcn_r == ncn_r) begin
								pend_r <= 1'b1;
								act_r  <= 1'b0;
								st_r   <= FHPC_D_IDLE;
							end else begin
								dir_r  <= pcn_r < ncn_r;
								step_r <= 1'b1;
								tmr_r  <= PULSE_T;
								st_r   <= FHPC_D_PULSE;
							end
						end
						FHPC_D_PULSE: begin
							tmr_r <= tmr_r - 1'b1;
							if (tmr_r == PULSE_T - TW'(STEP_PULSE_CYC - 1) || tmr_r <= 1) begin
								step_r <= 1'b0;
								// the compare state eats one cycle of the interval
								tmr_r  <= step_gap - PULSE_T - TW'(1);
								st_r   <= FHPC_D_WAIT;
								if (recal_r)
									cnt_r <= cnt_r + 7'h01;
								else if (dir_r)
									pcn_r <= pcn_r + 8'h01;
								else
									pcn_r <= pcn_r - 8'h01;
							end
						end
						FHPC_D_WAIT: begin
							tmr_r <= tmr_r - 1'b1;
							if (tmr_r <= 1)
								st_r <= FHPC_D_EVAL;
						end
						default: st_r <= FHPC_D_IDLE;
					endcase
				end
			end
			assign pcn_w[gi]        = pcn_r;
			assign pend_w[gi]       = pend_r;
			assign ic_w[gi]         = ic_r;
			assign ec_w[gi]         = ec_r;
			assign STEP_OUT[gi]     = step_r;
			assign DIR_OUT[gi]      = dir_r;
			assign DRIVE_ACTIVE[gi] = act_r;
		end
	endgenerate

	// read-id: latch first id field, give up on the second index
	fhpc_rid_e  rid_r;
	logic [1:0] idx_cnt_r;
	logic       rid_pend_r, rid_ma_r;
	logic [1:0] rid_drv_r;
	assign rid_busy = rid_r != FHPC_R_IDLE;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			rid_r      <= FHPC_R_IDLE;
			idx_cnt_r  <= 2'h0;
			rid_pend_r <= 1'b0;
			rid_ma_r   <= 1'b0;
			rid_drv_r  <= 2'h0;
			ID_CHRN    <= 32'h0;
		end else begin
			if (take && CMD_CODE == CMD_SENSE && rid_pend_r)
				rid_pend_r <= 1'b0;
			if (lp_exit) begin
				rid_ma_r   <= 1'b0;
				rid_pend_r <= 1'b0;
			end
			case (rid_r)
				FHPC_R_IDLE: begin
					if (take && CMD_CODE == CMD_READ_ID) begin
						rid_r     <= FHPC_R_SEARCH;
						idx_cnt_r <= 2'h0;
						rid_ma_r  <= 1'b0;
						rid_drv_r <= CMD_DRIVE;
					end
				end
				FHPC_R_SEARCH: begin
					if (ID_VALID) begin
						ID_CHRN    <= {ID_CYL, ID_HEAD, ID_SECTOR, ID_SIZE};
						rid_pend_r <= 1'b1;
						rid_r      <= FHPC_R_IDLE;
					end else if (idx_rise) begin
						idx_cnt_r <= idx_cnt_r + 2'h1;
						if (idx_cnt_r == 2'h1) begin
							rid_ma_r   <= 1'b1;
							rid_pend_r <= 1'b1;
							rid_r      <= FHPC_R_IDLE;
						end
					end
				end
				default: rid_r <= FHPC_R_IDLE;
			endcase
		end
	end
	assign MISSING_ADDRESS_MARK_FLAG = rid_ma_r;

	// lowest pending drive is the one a sense-interrupt reports
	function automatic logic [2:0] first_pending(input logic pend [NDRV]);
		logic [2:0] r;
		r = 3'h4;
		for (int i = NDRV - 1; i >= 0; i--)
			if (pend[i])
				r = 3'(i);
		return r;
	endfunction
	wire [2:0] pick = first_pending(pend_w);

	always_comb begin
		clr_int = '0;
		if (take && CMD_CODE == CMD_SENSE && !rid_pend_r && !pick[2])
			clr_int[pick[1:0]] = 1'b1;
	end

	// sense-interrupt result and interrupt line
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			FIRST_STATUS_BYTE <= 8'h00;
			PRESENT_CYLINDER  <= 8'h00;
			INT_OUT           <= 1'b0;
			BUSY              <= 1'b0;
		end else begin
			// busy only while a command other than sense or read-id is taken, or read-id runs
			BUSY    <= (take && CMD_CODE != CMD_READ_ID && CMD_CODE != CMD_SENSE)
				|| rid_busy;
			INT_OUT <= rid_pend_r || !pick[2];
			if (lp_exit) begin
				FIRST_STATUS_BYTE <= 8'h00;
				PRESENT_CYLINDER  <= 8'h00;
			end else if (take && CMD_CODE == CMD_SENSE) begin
				if (rid_pend_r) begin
					FIRST_STATUS_BYTE <= {(rid_ma_r ? IC_ABNORMAL : IC_NORMAL),
						4'h0, rid_drv_r};
				end else if (!pick[2]) begin
					FIRST_STATUS_BYTE <= 8'h00;
					FIRST_STATUS_BYTE[ST0_IC_HI -: 2] <= ic_w[pick[1:0]];
					FIRST_STATUS_BYTE[ST0_SE]   <= 1'b1;
					FIRST_STATUS_BYTE[ST0_EC]   <= ec_w[pick[1:0]];
					FIRST_STATUS_BYTE[ST0_HEAD] <= 1'b0;
					FIRST_STATUS_BYTE[1:0]      <= pick[1:0];
					PRESENT_CYLINDER            <= pcn_w[pick[1:0]];
				end else begin
					FIRST_STATUS_BYTE <= ST0_INVALID;
				end
			end
		end
	end

	// single density layout lookup for the formatter
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			FMT_BYTE  <= 8'h00;
			FMT_COUNT <= 8'h00;
		end else begin
			case (fhpc_field_e'(FMT_FIELD))
				FHPC_F_GAP4A: begin FMT_BYTE <= GAP_FILL;    FMT_COUNT <= GAP4A_LEN; end
				FHPC_F_SYNC:  begin FMT_BYTE <= SYNC_FILL;   FMT_COUNT <= SYNC_LEN;  end
				FHPC_F_IAM:   begin FMT_BYTE <= MARK_INDEX;  FMT_COUNT <= ONE_BYTE;  end
				FHPC_F_GAP1:  begin FMT_BYTE <= GAP_FILL;    FMT_COUNT <= GAP1_LEN;  end
				FHPC_F_IDAM:  begin FMT_BYTE <= MARK_ID;     FMT_COUNT <= ONE_BYTE;  end
				FHPC_F_GAP2:  begin FMT_BYTE <= GAP_FILL;    FMT_COUNT <= GAP2_LEN;  end
				FHPC_F_DAM:   begin FMT_BYTE <= MARK_DATA;   FMT_COUNT <= ONE_BYTE;  end
				default:      begin FMT_BYTE <= MARK_DELETE; FMT_COUNT <= ONE_BYTE;  end
			endcase
		end
	end
endmodule : fhpc_ctrl

// File: fhpc_pkg.sv
package fhpc_pkg;
	// command codes presented on CMD_CODE
	localparam logic [2:0] CMD_SEEK    = 3'h0;
	localparam logic [2:0] CMD_RECAL   = 3'h1;
	localparam logic [2:0] CMD_READ_ID = 3'h2;
	localparam logic [2:0] CMD_SENSE   = 3'h3;
	localparam logic [2:0] CMD_SPECIFY = 3'h4;

	// interrupt code field values
	localparam logic [1:0] IC_NORMAL   = 2'h0;
	localparam logic [1:0] IC_ABNORMAL = 2'h1;
	localparam logic [7:0] ST0_INVALID = 8'h80;

	// first status byte field positions
	localparam int ST0_IC_HI = 7;
	localparam int ST0_SE    = 5;
	localparam int ST0_EC    = 4;
	localparam int ST0_HEAD  = 2;

	// head positioning
	localparam logic [6:0] RECAL_MAX_STEPS = 7'h4f;
	localparam logic [4:0] SRT_BASE        = 5'h10;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int STEP_PULSE_NS   = 1000;
	localparam int STEP_PULSE_CYC  = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_UNIT_NS    = 1000000;
	localparam int STEP_UNIT_CYC   = STEP_UNIT_NS / CLK_PERIOD_NS;

	// single density track layout
	localparam logic [7:0] GAP_FILL    = 8'hff;
	localparam logic [7:0] SYNC_FILL   = 8'h00;
	localparam logic [7:0] GAP4A_LEN   = 8'h28;
	localparam logic [7:0] GAP1_LEN    = 8'h1a;
	localparam logic [7:0] GAP2_LEN    = 8'h0b;
	localparam logic [7:0] SYNC_LEN    = 8'h06;
	localparam logic [7:0] MARK_INDEX  = 8'hfc;
	localparam logic [7:0] MARK_ID     = 8'hfe;
	localparam logic [7:0] MARK_DATA   = 8'hfb;
	localparam logic [7:0] MARK_DELETE = 8'hf8;
	localparam logic [7:0] ONE_BYTE    = 8'h01;

	typedef enum logic [2:0] {
		FHPC_F_GAP4A, FHPC_F_SYNC, FHPC_F_IAM, FHPC_F_GAP1,
		FHPC_F_IDAM, FHPC_F_GAP2, FHPC_F_DAM, FHPC_F_DDAM
	} fhpc_field_e;
endpackage : fhpc_pkg

// File: fhpc_assertions.sv
`timescale 1ns/10ps
module fhpc_assertions
	import fhpc_pkg::*;
#(
	parameter int NDRV = 4
) (
	input wire logic            MCLK,
	input wire logic            RSTN,
	input wire logic            CMD_VALID,
	input wire logic [2:0]      CMD_CODE,
	input wire logic [1:0]      CMD_DRIVE,
	input wire logic            LOW_POWER,
	input wire logic [2:0]      FMT_FIELD,
	input wire logic            BUSY,
	input wire logic            INT_OUT,
	input wire logic [7:0]      FIRST_STATUS_BYTE,
	input wire logic            MISSING_ADDRESS_MARK_FLAG,
	input wire logic [NDRV-1:0] STEP_OUT,
	input wire logic [NDRV-1:0] DIR_OUT,
	input wire logic [NDRV-1:0] DRIVE_ACTIVE,
	input wire logic [7:0]      FMT_BYTE,
	input wire logic [7:0]      FMT_COUNT
);
	// the design holds its own reset two edges past RSTN, so wait three
	logic [2:0] up_r;
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			up_r <= 3'h0;
		else
			up_r <= {up_r[1:0], 1'b1};
	end

	// length of the current high run on drive 0 step
	logic [7:0] hi_r;
	always_ff @(posedge MCLK) begin
		hi_r <= STEP_OUT[0] ? hi_r + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!up_r[2]);

	// exact pulse length, a short pulse would slip past a_step_width
	a_step_len: assert property ($fell(STEP_OUT[0]) |-> hi_r == 8'(STEP_PULSE_CYC))
		else $error("step pulse length not exact");

	// pulse high for its first 8 cycles and low again 20 cycles after the rise, whatever the step rate
	a_step_width: assert property ($rose(STEP_OUT[0]) |-> STEP_OUT[0] [*8] ##13 !STEP_OUT[0])
		else $error("step pulse width wrong");
	// direction must not move under a step the drive is latching
	a_dir_held: assert property (STEP_OUT[0] && $past(STEP_OUT[0]) |-> $stable(DIR_OUT[0]))
		else $error("direction changed during step");
	a_step_active: assert property (STEP_OUT[0] |-> DRIVE_ACTIVE[0])
		else $error("step without running positioner");
	a_head_zero: assert property (FIRST_STATUS_BYTE[ST0_HEAD] == 1'b0)
		else $error("head bit set in status");
	a_seek_busy: assert property (CMD_VALID && CMD_CODE == CMD_SEEK && !BUSY
		&& !DRIVE_ACTIVE[CMD_DRIVE] ##1 !CMD_VALID |-> BUSY ##1 !BUSY)
		else $error("busy not limited to command phase");
	a_idle_sense: assert property (CMD_VALID && CMD_CODE == CMD_SENSE && !BUSY && !$past(BUSY)
		&& !INT_OUT && !(|$past(DRIVE_ACTIVE, 3)) |=> FIRST_STATUS_BYTE == 8'h80)
		else $error("idle sense result wrong");
	a_end_int: assert property ($fell(DRIVE_ACTIVE[0]) && !$past(LOW_POWER, 2)
		|-> ##[0:3] INT_OUT)
		else $error("no interrupt after positioning end");
	a_ma_int: assert property ($rose(MISSING_ADDRESS_MARK_FLAG) |-> ##[0:3] INT_OUT)
		else $error("no interrupt after missing mark");
	a_fmt_gap4a: assert property (FMT_FIELD == 3'h0 |=> FMT_BYTE == 8'hff && FMT_COUNT == 8'h28)
		else $error("pre-index gap wrong");
	a_fmt_gap2: assert property (FMT_FIELD == 3'h5 |=> FMT_BYTE == 8'hff && FMT_COUNT == 8'h0b)
		else $error("id to data gap wrong");
endmodule : fhpc_assertions

bind fhpc_ctrl fhpc_assertions #(.NDRV(NDRV)) i_chk (.MCLK, .RSTN, .CMD_VALID, .CMD_CODE,
	.CMD_DRIVE, .LOW_POWER, .FMT_FIELD, .BUSY, .INT_OUT, .FIRST_STATUS_BYTE,
	.MISSING_ADDRESS_MARK_FLAG, .STEP_OUT, .DIR_OUT, .DRIVE_ACTIVE, .FMT_BYTE, .FMT_COUNT);

// File: fhpc_drive_model.sv
`timescale 1ns/10ps
module fhpc_drive_model #(
	parameter logic [31:0] START = 32'h0000_6403
) (
	input  wire logic       clk,
	input  wire logic [3:0] step,
	input  wire logic [3:0] dir,
	output logic      [3:0] tz
);
	logic [7:0] pos_r [4];
	logic [3:0] step_q_r;

	initial begin
		step_q_r = 4'h0;
		for (int i = 0; i < 4; i++) pos_r[i] = START[i*8 +: 8];
	end

	// head moves on the leading step edge; a real head cannot pass track zero
	always @(posedge clk) begin
		step_q_r <= step;
		for (int i = 0; i < 4; i++) begin
			if (step[i] && !step_q_r[i] && dir[i]) pos_r[i] <= pos_r[i] + 8'h01;
			else if (step[i] && !step_q_r[i] && pos_r[i] != 8'h00) pos_r[i] <= pos_r[i] - 8'h01;
		end
	end

	// track-zero sensor high only at cylinder 0
	always_comb begin
		for (int i = 0; i < 4; i++) tz[i] = (pos_r[i] == 8'h00);
	end
endmodule : fhpc_drive_model

// File: tb.sv
`timescale 1ns/10ps
module tb
	import fhpc_pkg::*;
;
	logic        MCLK = 1'b0, RSTN = 1'b0, CMD_VALID = 1'b0, LOW_POWER = 1'b0;
	logic        INDEX_PULSE_INPUT = 1'b0, ID_VALID = 1'b0, dir0 = 1'b0;
	logic [2:0]  CMD_CODE = 3'h0, FMT_FIELD = 3'h0;
	logic [1:0]  CMD_DRIVE = 2'h0;
	logic [7:0]  CMD_ARG = 8'h00, ID_CYL = 8'h00, ID_HEAD = 8'h00;
	logic [7:0]  ID_SECTOR = 8'h00, ID_SIZE = 8'h00;
	logic [3:0]  tz, step, dirs, act, sq = 4'h0;
	wire         busy, int_out, mamf;
	wire  [7:0]  st0, present_cylinder, fb, fc;
	wire  [31:0] chrn;
	int          miscompares = 0, check_count = 0, cyc = 0, ivl = 0, gap = 0;
	int          nst [4] = '{0, 0, 0, 0};
	// field, fill byte, repeat count
	localparam logic [18:0] FT [8] = '{19'h0ff28, 19'h10006, 19'h2fc01, 19'h3ff1a,
		19'h4fe01, 19'h5ff0b, 19'h6fb01, 19'h7f801};

	initial forever #25 MCLK = ~MCLK;

	fhpc_ctrl #(.NDRV(4), .STEP_MS_CYC(40)) i_dut (.MCLK(MCLK), .RSTN(RSTN),
		.CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_DRIVE(CMD_DRIVE), .CMD_ARG(CMD_ARG),
		.LOW_POWER(LOW_POWER), .TRACK_ZERO_INPUT(tz), .INDEX_PULSE_INPUT(INDEX_PULSE_INPUT),
		.ID_VALID(ID_VALID), .ID_CYL(ID_CYL), .ID_HEAD(ID_HEAD), .ID_SECTOR(ID_SECTOR),
		.ID_SIZE(ID_SIZE), .FMT_FIELD(FMT_FIELD), .BUSY(busy), .INT_OUT(int_out),
		.FIRST_STATUS_BYTE(st0), .PRESENT_CYLINDER(present_cylinder), .MISSING_ADDRESS_MARK_FLAG(mamf),
		.ID_CHRN(chrn), .STEP_OUT(step), .DIR_OUT(dirs), .DRIVE_ACTIVE(act),
		.FMT_BYTE(fb), .FMT_COUNT(fc));

	fhpc_drive_model i_drv (.clk(MCLK), .step(step), .dir(dirs), .tz(tz));

	// counts step edges per drive, interval and direction on drive 0
	always @(posedge MCLK) begin
		sq <= step;
		gap <= gap + 1;
		for (int i = 0; i < 4; i++) if (step[i] && !sq[i]) nst[i] <= nst[i] + 1;
		if (step[0] && !sq[0]) begin
			ivl <= gap;
			gap <= 1;
			dir0 <= dirs[0];
		end
	end

	// a hang ends the run as a failure
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic close_out;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cmd(input logic [2:0] c, input logic [1:0] d, input logic [7:0] a);
		@(posedge MCLK) #5;
		CMD_VALID = 1'b1;
		CMD_CODE = c;
		CMD_DRIVE = d;
		CMD_ARG = a;
		@(posedge MCLK) #5;
		CMD_VALID = 1'b0;
	endtask : cmd

	// bounded wait; a missing interrupt is counted by the check at its end
	task automatic wait_int;
		for (int n = 0; n < 5000 && int_out !== 1'b1; n++) @(posedge MCLK) #5;
		chk(int_out, 32'h1);
	endtask : wait_int

	task automatic sense(input logic [7:0] exp);
		cmd(CMD_SENSE, 2'h0, 8'h00);
		@(posedge MCLK) #5;
		chk(st0, exp);
	endtask : sense

	initial begin
		repeat (6) @(posedge MCLK);
		#5 chk({busy, int_out, step, st0}, 32'h0);
		RSTN = 1'b1;
		repeat (4) @(posedge MCLK);
		for (int k = 0; k < 8; k++) begin
			@(posedge MCLK) #5 FMT_FIELD = FT[k][18:16];
			@(posedge MCLK) #5 chk({fb, fc}, FT[k][15:0]);
		end
		sense(8'h80);
		cmd(CMD_SPECIFY, 2'h0, 8'h0f);
		repeat (3) @(posedge MCLK);
		#5 chk(int_out, 32'h0);
		cmd(CMD_RECAL, 2'h0, 8'h00);
		cmd(CMD_RECAL, 2'h1, 8'h00);
		wait_int;
		sense(8'h20);
		chk(present_cylinder, 32'h0);
		chk({dir0, nst[0][7:0]}, 32'h003);
		cmd(CMD_SEEK, 2'h0, 8'h05);
		chk({busy, act}, 32'h13);
		@(posedge MCLK) #5 chk(busy, 32'h0);
		wait_int;
		sense(8'h20);
		chk({dir0, present_cylinder, nst[0][7:0]}, 32'h10508);
		chk(ivl, 32'd40);
		cmd(CMD_SEEK, 2'h0, 8'h02);
		wait_int;
		sense(8'h20);
		chk({dir0, present_cylinder, nst[0][7:0]}, 32'h0020b);
		wait_int;
		sense(8'h71);
		chk(nst[1], 32'd79);
		cmd(CMD_READ_ID, 2'h2, 8'h00);
		@(posedge MCLK) #5;
		{ID_VALID, ID_CYL, ID_HEAD, ID_SECTOR, ID_SIZE} = {1'b1, 32'h12013402};
		@(posedge MCLK) #5 ID_VALID = 1'b0;
		wait_int;
		chk(chrn, 32'h12013402);
		sense(8'h02);
		cmd(CMD_READ_ID, 2'h3, 8'h00);
		repeat (2) begin
			@(posedge MCLK) #5 INDEX_PULSE_INPUT = 1'b1;
			repeat (4) @(posedge MCLK);
			#5 INDEX_PULSE_INPUT = 1'b0;
			repeat (20) @(posedge MCLK);
		end
		wait_int;
		chk(mamf, 32'h1);
		sense(8'h43);
		@(posedge MCLK) #5 LOW_POWER = 1'b1;
		repeat (4) @(posedge MCLK);
		#5 LOW_POWER = 1'b0;
		repeat (4) @(posedge MCLK);
		#5 chk({st0, present_cylinder}, 32'h0);
		cmd(CMD_SEEK, 2'h0, 8'h01);
		wait_int;
		sense(8'h20);
		chk({dir0, present_cylinder}, 32'h101);
		close_out();
	end
endmodule : tb
